// ### hw/tmr2c_top.sv
// Purpose: control, count and flag logic of the second 16-bit timer
// Assumes: apb slave, pclk at 200 MHz, pins asynchronous to pclk
// Notes:   serial clock outputs are one-cycle overflow strobes
// What this block does
// - overflow flag set only when serial selects zero
// - trigger fall with enable sets external flag
// - set external flag raises timer interrupt
// - no external interrupt while direction enable set
// - receive select picks timer1 or own overflow
// - transmit select picks timer1 or own overflow
// - trigger ignored unless enabled and not baud
// - count only while run control set
// - count peripheral clock or count pin falls
// - serial clock selection forces auto-reload mode, except down counting in direction mode
// - reload on overflow and enabled trigger falls
// - capture count on enabled trigger falls

`timescale 1ns/100ps

module tmr2c_top #(
  parameter int WIDTH = 16
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        count_pin,
  input  wire logic        trigger_pin,
  // serial port clocking
  input  wire logic        timer1_overflow,
  output logic             serial_rx_clock,
  output logic             serial_tx_clock,
  // interrupt
  output logic             timer_irq
);
  // control register and its fields
  logic [7:0]       control_reg;
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] reload_reg;
  logic [1:0]       mode_reg;
  logic [tmr2c_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [tmr2c_pkg::IRQ_W-1:0] irq_en_reg;
  logic [WIDTH-1:0] count_next;
  logic [31:0]      rdata_next;
  logic             ovf_flag;
  logic             ext_flag;
  logic             rx_sel;
  logic             tx_sel;
  logic             trig_en;
  logic             run;
  logic             cnt_sel;
  logic             cap_sel;
  logic             dir_en;
  logic             dir_up;
  logic             baud_mode;
  logic             count_fall;
  logic             trig_fall;
  logic             tick;
  logic             overflow;
  logic             trig_event;
  logic             do_capture;
  logic             do_reload;
  logic             wr_access;
  logic             rd_access;
  logic             addr_ok;

  assign ovf_flag = control_reg[tmr2c_pkg::BIT_OVF];
  assign ext_flag = control_reg[tmr2c_pkg::BIT_EXT];
  assign rx_sel   = control_reg[tmr2c_pkg::BIT_RXSEL];
  assign tx_sel   = control_reg[tmr2c_pkg::BIT_TXSEL];
  assign trig_en  = control_reg[tmr2c_pkg::BIT_TRIG_EN];
  assign run      = control_reg[tmr2c_pkg::BIT_RUN];
  assign cnt_sel  = control_reg[tmr2c_pkg::BIT_CNT_SEL];
  assign cap_sel  = control_reg[tmr2c_pkg::BIT_CAP_SEL];
  assign dir_en   = mode_reg[tmr2c_pkg::BIT_DIR_EN];
  assign dir_up   = mode_reg[tmr2c_pkg::BIT_DIR_UP];

  // pin synchronisers and edge detectors
  tmr2c_fall_det u_count_det (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (count_pin),
    .fall    (count_fall)
  );

  tmr2c_fall_det u_trig_det (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (trigger_pin),
    .fall    (trig_fall)
  );

  // count source and gating
  assign baud_mode = rx_sel | tx_sel;
  assign tick      = run & (cnt_sel ? count_fall : 1'b1);
  // down counting in direction mode wraps at the reload value
  assign overflow  = tick & ((dir_en & ~dir_up) ? (count_reg == reload_reg)
                                                 : (count_reg == tmr2c_pkg::COUNT_MAX));
  // trigger acts only when enabled and not clocking the serial port
  assign trig_event = trig_fall & trig_en & ~baud_mode;
  assign do_capture = trig_event & cap_sel & ~dir_en;
  assign do_reload  = overflow | (trig_event & ~cap_sel & ~dir_en);

  // serial clock strobes
  assign serial_rx_clock = rx_sel ? overflow : timer1_overflow;
  assign serial_tx_clock = tx_sel ? overflow : timer1_overflow;

  // next counter value
  always_comb begin
    count_next = count_reg;
    if (do_reload) begin
      if (overflow && dir_en && !dir_up) begin
        count_next = tmr2c_pkg::COUNT_MAX;
      end else begin
        count_next = reload_reg;
      end
    end else if (tick) begin
      if (dir_en && !dir_up) begin
        count_next = count_reg - WIDTH'(1);
      end else begin
        count_next = count_reg + WIDTH'(1);
      end
    end
  end

  // apb decode
  assign wr_access = psel & penable & pwrite;
  assign rd_access = psel & ~penable & ~pwrite;
  assign pready    = 1'b1;
  assign addr_ok   = (paddr == tmr2c_pkg::ADDR_CONTROL)  | (paddr == tmr2c_pkg::ADDR_COUNT)
                   | (paddr == tmr2c_pkg::ADDR_RELOAD)   | (paddr == tmr2c_pkg::ADDR_MODE)
                   | (paddr == tmr2c_pkg::ADDR_IRQ_STAT) | (paddr == tmr2c_pkg::ADDR_IRQ_EN)
                   | (paddr == tmr2c_pkg::ADDR_IRQ_CLR);
  assign pslverr   = psel & penable & ~addr_ok;

  // counter register; software write wins over counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= tmr2c_pkg::COUNT_RESET;
    end else if (wr_access && paddr == tmr2c_pkg::ADDR_COUNT) begin
      count_reg <= pwdata[WIDTH-1:0];
    end else begin
      count_reg <= count_next;
    end
  end

  // capture/reload register; capture beats a write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_reg <= tmr2c_pkg::RELOAD_RESET;
    end else if (do_capture) begin
      reload_reg <= count_reg;
    end else if (wr_access && paddr == tmr2c_pkg::ADDR_RELOAD) begin
      reload_reg <= pwdata[WIDTH-1:0];
    end
  end

  // control register; hardware flag sets win over software clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= tmr2c_pkg::CONTROL_RESET;
    end else begin
      if (wr_access && paddr == tmr2c_pkg::ADDR_CONTROL) begin
        control_reg <= pwdata[7:0];
      end
      if (overflow && !baud_mode) begin
        control_reg[tmr2c_pkg::BIT_OVF] <= 1'b1;
      end
      if (trig_event) begin
        control_reg[tmr2c_pkg::BIT_EXT] <= 1'b1;
      end
    end
  end

  // direction mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= tmr2c_pkg::MODE_RESET;
    end else if (wr_access && paddr == tmr2c_pkg::ADDR_MODE) begin
      mode_reg <= pwdata[1:0];
    end
  end

  // sticky interrupt status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
    end else begin
      if (wr_access && paddr == tmr2c_pkg::ADDR_IRQ_CLR) begin
        irq_stat_reg <= irq_stat_reg & ~pwdata[tmr2c_pkg::IRQ_W-1:0];
      end
      if (overflow && !baud_mode) begin
        irq_stat_reg[tmr2c_pkg::IRQ_OVF] <= 1'b1;
      end
      if (trig_event && !dir_en) begin
        irq_stat_reg[tmr2c_pkg::IRQ_EXT] <= 1'b1;
      end
    end
  end

  // interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= '0;
    end else if (wr_access && paddr == tmr2c_pkg::ADDR_IRQ_EN) begin
      irq_en_reg <= pwdata[tmr2c_pkg::IRQ_W-1:0];
    end
  end

  // the external flag in control also gates the vector, so clearing either stops it
  assign timer_irq = (irq_stat_reg[tmr2c_pkg::IRQ_OVF] & irq_en_reg[tmr2c_pkg::IRQ_OVF] & ovf_flag)
                   | (irq_stat_reg[tmr2c_pkg::IRQ_EXT] & irq_en_reg[tmr2c_pkg::IRQ_EXT]
                      & ext_flag & ~dir_en);

  // read mux, registered in setup so data stands through the access phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      tmr2c_pkg::ADDR_CONTROL:  rdata_next[7:0]              = control_reg;
      tmr2c_pkg::ADDR_COUNT:    rdata_next[WIDTH-1:0]        = count_reg;
      tmr2c_pkg::ADDR_RELOAD:   rdata_next[WIDTH-1:0]        = reload_reg;
      tmr2c_pkg::ADDR_MODE:     rdata_next[1:0]              = mode_reg;
      tmr2c_pkg::ADDR_IRQ_STAT: rdata_next[tmr2c_pkg::IRQ_W-1:0] = irq_stat_reg;
      tmr2c_pkg::ADDR_IRQ_EN:   rdata_next[tmr2c_pkg::IRQ_W-1:0] = irq_en_reg;
      default:                  rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_access) begin
      prdata <= rdata_next;
    end
  end
endmodule : tmr2c_top

// ### hw/tmr2c_pkg.sv
// Purpose: shared constants for the timer two control unit
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   control register sits at its printed byte offset

package tmr2c_pkg;
  // register byte offsets
  localparam logic [7:0]  ADDR_CONTROL   = 8'hc8;
  localparam logic [7:0]  ADDR_COUNT     = 8'hcc;
  localparam logic [7:0]  ADDR_RELOAD    = 8'hd0;
  localparam logic [7:0]  ADDR_MODE      = 8'hd4;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'hd8;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'hdc;
  localparam logic [7:0]  ADDR_IRQ_CLR   = 8'he0;
  // control register field positions
  localparam int          BIT_OVF        = 7;
  localparam int          BIT_EXT        = 6;
  localparam int          BIT_RXSEL      = 5;
  localparam int          BIT_TXSEL      = 4;
  localparam int          BIT_TRIG_EN    = 3;
  localparam int          BIT_RUN        = 2;
  localparam int          BIT_CNT_SEL    = 1;
  localparam int          BIT_CAP_SEL    = 0;
  // mode register field positions
  localparam int          BIT_DIR_EN     = 0;
  localparam int          BIT_DIR_UP     = 1;
  // interrupt status field positions
  localparam int          IRQ_OVF        = 0;
  localparam int          IRQ_EXT        = 1;
  localparam int          IRQ_W          = 2;
  // reset values and count limits
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] RELOAD_RESET   = 16'h0000;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;
  localparam logic [15:0] COUNT_MIN      = 16'h0000;
endpackage : tmr2c_pkg

// ### hw/tmr2c_fall_det.sv
// Purpose: two-flop synchroniser and falling edge detector for a pin
// Assumes: pin is asynchronous to pclk
// Notes:   edge pulse is one cycle, two edges after the pin falls

`timescale 1ns/100ps

module tmr2c_fall_det (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and result
  input  wire logic pin,
  output logic      fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // only sync_reg reads the first flop, so metastability stays contained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign fall = last_reg & ~sync_reg;
endmodule : tmr2c_fall_det

// ### verif/tmr2c_pins.sv
// Purpose: far-side pin model driving count and trigger pins
// Assumes: both pins idle high through a pull-up
// Notes:   a go pulse gives one falling edge, low for 4 cycles
`timescale 1ns/100ps
module tmr2c_pins (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // requests
  input  wire logic cnt_go,
  input  wire logic trg_go,
  // pins
  output logic      count_pin,
  output logic      trigger_pin
);
  logic [2:0] cnt_low, trg_low;
  // low long enough for the two-flop synchroniser to see it
  // reset puts both pins at their pull-up level, so no fall is seen at release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_low <= 3'h0;
      trg_low <= 3'h0;
    end else begin
      cnt_low <= cnt_go ? 3'h4 : (cnt_low != 3'h0 ? cnt_low - 3'h1 : 3'h0);
      trg_low <= trg_go ? 3'h4 : (trg_low != 3'h0 ? trg_low - 3'h1 : 3'h0);
    end
  end
  assign count_pin   = (cnt_low == 3'h0);
  assign trigger_pin = (trg_low == 3'h0);
endmodule : tmr2c_pins

// ### verif/tmr2c_chk.sv
// Purpose: port-level checker for the timer two control unit
// Assumes: zero wait state apb, shadows track software writes
// Notes:   hardware-set bits are not shadowed, only selects, interrupt enables and direction enable
`timescale 1ns/100ps
module tmr2c_chk (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial and interrupt
  input wire logic        timer1_overflow,
  input wire logic        serial_rx_clock,
  input wire logic        serial_tx_clock,
  input wire logic        timer_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       acc, mapped;
  logic [1:0] sel_q, en_q;
  logic       dir_q;
  assign acc    = psel & penable;
  assign mapped = paddr inside {8'hc8, 8'hcc, 8'hd0, 8'hd4, 8'hd8, 8'hdc, 8'he0};
  // shadow of software-only select and enable bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 2'h0;
      en_q  <= 2'h0;
      dir_q <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == tmr2c_pkg::ADDR_CONTROL) sel_q <= pwdata[5:4];
      if (paddr == tmr2c_pkg::ADDR_IRQ_EN) en_q <= pwdata[1:0];
      if (paddr == tmr2c_pkg::ADDR_MODE) dir_q <= pwdata[0];
    end
  end
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
  a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("error on mapped");
  a_rx_timer1: assert property (!sel_q[1] |-> serial_rx_clock == timer1_overflow) else $error("rx clock");
  a_tx_timer1: assert property (!sel_q[0] |-> serial_tx_clock == timer1_overflow) else $error("tx clock");
  a_irq_masked: assert property (en_q == 2'h0 |-> !timer_irq) else $error("irq while masked");
  a_irq_dir: assert property (dir_q && !en_q[0] |-> !timer_irq) else $error("irq in direction mode");
  a_read_unmapped: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0) else $error("unmapped data");
  a_ctl_upper: assert property (acc && !pwrite && paddr == 8'hc8 |-> prdata[31:8] == 24'h0) else $error("upper bits");
  c_irq: cover property ($rose(timer_irq));
  c_err: cover property (acc && pslverr);
  c_tx_sel: cover property (sel_q[0] && serial_tx_clock);
endmodule : tmr2c_chk
bind tmr2c_top tmr2c_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer1_overflow(timer1_overflow), .serial_rx_clock(serial_rx_clock), .serial_tx_clock(serial_tx_clock),
  .timer_irq(timer_irq));

// ### verif/testbench.sv
// Purpose: self-checking bench for the timer two control unit
// Assumes: reads are scored from a queue by a monitor
// Notes:   pins are stepped by the far-side model, one fall per go
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, t1_ovf, cnt_go, trg_go;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, exp_d;
  logic [31:0] t1s = 32'ha221fd89;
  logic        pready, pslverr, count_pin, trigger_pin, rx_clk, tx_clk, timer_irq;
  logic [31:0] exp_q[$];
  int          err_count, cmp_count, cyc;
  tmr2c_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_pin(count_pin), .trigger_pin(trigger_pin), .timer1_overflow(t1_ovf),
    .serial_rx_clock(rx_clk), .serial_tx_clock(tx_clk), .timer_irq(timer_irq));
  tmr2c_pins u_pins (.pclk(pclk), .presetn(presetn), .cnt_go(cnt_go), .trg_go(trg_go), .count_pin(count_pin),
    .trigger_pin(trigger_pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // one falling edge on a pin, then time for the event to land
  task automatic fall(input logic trg);
    @(posedge pclk);
    if (trg) trg_go <= 1'b1; else cnt_go <= 1'b1;
    @(posedge pclk);
    trg_go <= 1'b0; cnt_go <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask : fall
  // read monitor: oldest note against read data at the access edge
  // pop once, so a mismatch print cannot pop the queue a second time
  always @(posedge pclk) if (psel && penable && !pwrite && pready) begin
    exp_d = exp_q.pop_front();
    `CHK(prdata, exp_d)
  end
  // timer 1 overflow strobes from a separate lfsr stream, plus timeout
  always @(posedge pclk) begin
    t1s <= lfsr(t1s);
    t1_ovf <= t1s[3];
    cyc++;
    if (cyc == 20000) begin err_count++; give_verdict(); end
  end
  initial begin pclk = 1'b0; forever #2.5 pclk = ~pclk; end
  initial begin
    {presetn, psel, penable, pwrite, cnt_go, trg_go} = 6'h0;
    paddr = 8'h0; pwdata = 32'h0; seed = 32'ha221fd89;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'hc8, 32'h0); rd(8'hcc, 32'h0); rd(8'hd8, 32'h0);
    rd(8'h40, 32'h0); rd(8'he0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(8'hd0, seed); rd(8'hd0, {16'h0, seed[15:0]});
    end
    wr(8'hcc, 32'h10); fall(1'b0); rd(8'hcc, 32'h10);
    wr(8'hc8, 32'h06); repeat (3) fall(1'b0); rd(8'hcc, 32'h13);
    wr(8'hd0, 32'h1234); wr(8'hcc, 32'hffff); fall(1'b0);
    rd(8'hcc, 32'h1234); rd(8'hc8, 32'h86); rd(8'hd8, 32'h1);
    wr(8'hdc, 32'h3); @(posedge pclk); `CHK(timer_irq, 1'b1)
    wr(8'he0, 32'h1); @(posedge pclk); `CHK(timer_irq, 1'b0)
    wr(8'hc8, 32'h16); wr(8'hcc, 32'hffff); fall(1'b0);
    rd(8'hc8, 32'h16); rd(8'hcc, 32'h1234);
    wr(8'hc8, 32'h09); wr(8'hcc, 32'h55); fall(1'b1);
    rd(8'hd0, 32'h55); rd(8'hc8, 32'h49); rd(8'hd8, 32'h2);
    @(posedge pclk); `CHK(timer_irq, 1'b1)
    wr(8'he0, 32'h2); wr(8'hc8, 32'h08); wr(8'hd0, 32'h77); wr(8'hcc, 32'h11); fall(1'b1);
    rd(8'hcc, 32'h77); rd(8'hc8, 32'h48);
    wr(8'hc8, 32'h00); wr(8'hcc, 32'h22); fall(1'b1); rd(8'hcc, 32'h22); rd(8'hc8, 32'h0);
    wr(8'he0, 32'h3); wr(8'hd4, 32'h1); wr(8'hc8, 32'h08); fall(1'b1);
    rd(8'hd8, 32'h0); `CHK(timer_irq, 1'b0)
    repeat (4) @(posedge pclk);
    give_verdict();
  end
endmodule : testbench
